// ---- verilog/pcde_defines.svh ----
`ifndef PCDE_DEFINES_SVH
`define PCDE_DEFINES_SVH
// How it works
// [RULE1] Replacement runs only when the PIN is enabled and not blocked; both values supplied.
// [RULE2] Replacement with matching current value reloads attempts to 3 and stores new value.
// [RULE3] Replacement mismatch decrements attempts and keeps the stored value.
// [RULE4] Three consecutive mismatches, kept across sessions, block the PIN until unlocked; presetn here reloads the count to 3 and clears the block.
// [RULE5] A replaced value is shared storage, so every channel sees it at once.
// [RULE6] Replacement frame: first parameter zero, length 10 hex, current then new 8 bytes.
// [RULE7] Disable with matching value reloads attempts to 3 and marks the PIN disabled.
// [RULE8] Disable mismatch decrements attempts and keeps the PIN enabled.
// [RULE9] Disable is refused when the PIN is already disabled or blocked.
// [RULE10] Three disable mismatches block the PIN until a successful unlock.
// [RULE11] Disable first parameter: 0 plain, 1 reserved, bit 8 selects substitute reference.
// [RULE12] Chosen substitute reference gets usage qualifier 08 and must be verified instead.
// [RULE13] Disabled PIN grants always access, or requires the substitute reference if chosen.
// [RULE14] Files listing several references become always accessible when any one is disabled.
// [RULE15] Each successful disable or enable re-validates the security environment.
// [RULE16] Disable and enable carry length 08 and one value; low five second-byte bits pick PIN.
// [RULE17] Enable with matching value reloads attempts to 3 and marks the PIN enabled.
// [RULE18] Enable mismatch decrements attempts and leaves the PIN disabled.
// [RULE19] Enable is refused when the PIN is already enabled or blocked.
// [RULE20] Enable mismatches block the PIN; blocked disabled grants, blocked enabled denies.
// [RULE21] Enabling ends substitution by writing qualifier 00 to the substitute reference.
// [RULE22] Mismatch returns retries-left status down to zero; later checks return blocked status.
// [RULE23] Successful unlock reloads unlock attempts to 10, PIN attempts to 3, and enables.
// [RULE24] Refused requests change nothing and return an error status.
`define PCDE_A_CMD       12'h000
`define PCDE_A_DATA0     12'h004
`define PCDE_A_DATA1     12'h008
`define PCDE_A_DATA2     12'h00C
`define PCDE_A_DATA3     12'h010
`define PCDE_A_STATUS    12'h014
`define PCDE_A_SEL       12'h018
`define PCDE_A_PIN_INFO  12'h01C
`define PCDE_A_FILE_REFS 12'h020
`define PCDE_A_FILE_ACC  12'h024
`define PCDE_A_KEYQ      12'h028
`define PCDE_RETRY_INIT  2'h3
`define PCDE_UNBLK_INIT  4'hA
`define PCDE_LC_DOUBLE   8'h10
`define PCDE_LC_SINGLE   8'h08
`define PCDE_USE_ALT     8'h08
`define PCDE_USE_NONE    8'h00
`define PCDE_SW_OK       16'h9000
`define PCDE_SW_RETRY    12'h63C
`define PCDE_SW_BLOCKED  16'h6983
`define PCDE_SW_COND     16'h6985
`define PCDE_SW_P1P2     16'h6A86
`define PCDE_SW_LEN      16'h6700
`define PCDE_SW_INS      16'h6D00
`endif

// ---- verilog/pcde_pkg.sv ----
package pcde_pkg;
  typedef enum logic [2:0] {PCDE_OP_NONE, PCDE_OP_CHANGE, PCDE_OP_DISABLE, PCDE_OP_ENABLE,
                            PCDE_OP_UNBLOCK} pcde_op_e;
  typedef enum logic [2:0] {PCDE_ACT_NONE, PCDE_ACT_OK, PCDE_ACT_MISS, PCDE_ACT_UNB_OK,
                            PCDE_ACT_UNB_MISS} pcde_act_e;
  typedef enum logic [1:0] {PCDE_AC_VERIFY, PCDE_AC_ALWAYS, PCDE_AC_ALT, PCDE_AC_NEVER} pcde_acc_e;
  typedef struct packed {
    logic [7:0] lc;
    logic [7:0] p2;
    logic [7:0] p1;
    logic [4:0] rsv;
    pcde_op_e   op;
  } pcde_cmd_s;
  typedef struct packed {
    logic [15:0] epoch;
    logic [15:0] sw;
  } pcde_stat_s;
endpackage

// ---- verilog/pcde_pin_cmd.sv ----
`timescale 1ns/1ps
`include "pcde_defines.svh"

module pcde_pin_cmd
  import pcde_pkg::*;
#(
  parameter int          NPIN         = 4,
  parameter logic [63:0] PIN_INIT     = 64'hFFFF_FFFF_3433_3231,
  parameter logic [63:0] UNBLOCK_CODE = 64'h3837_3635_3433_3231
)
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // security environment
  output logic             sec_env_reval
);

  localparam int IW = (NPIN > 1) ? $clog2(NPIN) : 1;

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic      [31:0]     prdata_q;
  logic                 pready_q, pslverr_q, reval_q;
  logic      [31:0]     data_q [4];
  pcde_cmd_s            last_cmd_q;
  pcde_stat_s           stat_q;
  logic      [4:0]      sel_q;
  logic      [NPIN-1:0] file_refs_q;
  logic      [63:0]     pin_val_q [NPIN];
  logic      [1:0]      retry_q [NPIN];
  logic      [3:0]      unb_q [NPIN];
  logic      [NPIN-1:0] ena_q;
  logic      [NPIN-1:0] alt_use_q;
  logic      [4:0]      alt_ref_q [NPIN];
  logic      [7:0]      keyq_q [32];

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state, response in second access cycle

  logic        acc, done, wr, mapped;
  logic [31:0] rd_d;
  assign acc  = psel & penable & ~pready_q;
  assign done = psel & penable & pready_q;
  assign wr   = done & pwrite & mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else
    begin
      pready_q  <= acc;
      pslverr_q <= acc & ~mapped;
      if (acc)
        prdata_q <= pwrite ? 32'h0 : rd_d;
    end
  end
  assign prdata        = prdata_q;
  assign pready        = pready_q;
  assign pslverr       = pslverr_q;
  assign sec_env_reval = reval_q;

  ////////////////////////////////////////////////////////////////////////////
  // command decode

  pcde_cmd_s     cmd;
  logic          cmd_go, ref_ok, p1_ok, lc_ok, blk, ublk, match, umatch;
  logic [IW-1:0] pix;
  logic [63:0]   old_val, new_val;
  pcde_act_e     act;
  logic [15:0]   sw_d;
  assign cmd     = pcde_cmd_s'(pwdata);
  assign cmd_go  = wr & (paddr == `PCDE_A_CMD);
  assign old_val = {data_q[1], data_q[0]};
  assign new_val = {data_q[3], data_q[2]};
  assign pix     = IW'(cmd.p2[4:0] - 5'h1);
  // reference number 1..NPIN, b6 b5 must be zero
  assign ref_ok  = (cmd.p2[6:5] == 2'b00) && (cmd.p2[4:0] != 5'h0) && (int'(cmd.p2[4:0]) <= NPIN); // RULE16
  assign blk     = retry_q[pix] == 2'h0;
  assign ublk    = unb_q[pix] == 4'h0;
  assign match   = old_val == pin_val_q[pix];
  assign umatch  = old_val == UNBLOCK_CODE;

  // unknown opcodes never pass the parameter check
  assign p1_ok = (cmd.op == PCDE_OP_DISABLE)
                 ? (cmd.p1 == 8'h00) || (cmd.p1[7] && cmd.p1[6:5] == 2'b00) // RULE11
                 : (cmd.p1 == 8'h00) && cmd.op inside {PCDE_OP_CHANGE, PCDE_OP_ENABLE, PCDE_OP_UNBLOCK};
  assign lc_ok = (cmd.op inside {PCDE_OP_CHANGE, PCDE_OP_UNBLOCK}) ? cmd.lc == `PCDE_LC_DOUBLE // RULE6
                                                                   : cmd.lc == `PCDE_LC_SINGLE; // RULE16

  // precedence: opcode, parameters, length, blocking, state, value
  always_comb
  begin
    act  = PCDE_ACT_NONE;
    sw_d = `PCDE_SW_OK;
    if (cmd.op == PCDE_OP_NONE || cmd.op > PCDE_OP_UNBLOCK)
      sw_d = `PCDE_SW_INS;
    else if (!p1_ok || !ref_ok)
      sw_d = `PCDE_SW_P1P2; // RULE24
    else if (!lc_ok)
      sw_d = `PCDE_SW_LEN; // RULE24
    else if (cmd.op == PCDE_OP_UNBLOCK)
    begin
      if (ublk)
        sw_d = `PCDE_SW_BLOCKED;
      else if (umatch)
        act = PCDE_ACT_UNB_OK;
      else
      begin
        act  = PCDE_ACT_UNB_MISS;
        sw_d = {`PCDE_SW_RETRY, 4'(unb_q[pix] - 4'h1)};
      end
    end
    else if (blk)
      sw_d = `PCDE_SW_BLOCKED; // RULE22
    else if ((cmd.op != PCDE_OP_ENABLE && !ena_q[pix]) || (cmd.op == PCDE_OP_ENABLE && ena_q[pix]))
      sw_d = `PCDE_SW_COND; // RULE1 RULE9 RULE19
    else if (match)
      act = PCDE_ACT_OK;
    else
    begin
      act  = PCDE_ACT_MISS;
      sw_d = {`PCDE_SW_RETRY, 4'({2'b00, retry_q[pix]} - 4'h1)}; // RULE22
    end
  end

  logic go_ok, go_miss, go_uok, go_alt, go_end_alt;
  assign go_ok      = cmd_go && act == PCDE_ACT_OK;
  assign go_miss    = cmd_go && act == PCDE_ACT_MISS;
  assign go_uok     = cmd_go && act == PCDE_ACT_UNB_OK;
  assign go_alt     = go_ok && cmd.op == PCDE_OP_DISABLE && cmd.p1[7];
  assign go_end_alt = ((go_ok && cmd.op == PCDE_OP_ENABLE) || go_uok) && alt_use_q[pix];

  ////////////////////////////////////////////////////////////////////////////
  // pin state, one array per concern; single copy shared by all channels

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < NPIN; i++)
        retry_q[i] <= `PCDE_RETRY_INIT;
    else if (go_ok || go_uok)
      retry_q[pix] <= `PCDE_RETRY_INIT; // RULE2 RULE7 RULE17 RULE23
    else if (go_miss)
      retry_q[pix] <= 2'(retry_q[pix] - 2'h1); // RULE3 RULE4 RULE8 RULE10 RULE18 RULE20
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < NPIN; i++)
        pin_val_q[i] <= PIN_INIT;
    else if ((go_ok && cmd.op == PCDE_OP_CHANGE) || go_uok)
      pin_val_q[pix] <= new_val; // RULE2 RULE5
  end
  // a blocked pin keeps its enable state; the optional force-enable is not taken
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ena_q <= '1;
    else if (go_ok && cmd.op == PCDE_OP_DISABLE)
      ena_q[pix] <= 1'b0; // RULE7
    else if ((go_ok && cmd.op == PCDE_OP_ENABLE) || go_uok)
      ena_q[pix] <= 1'b1; // RULE17 RULE23
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < NPIN; i++)
        unb_q[i] <= `PCDE_UNBLK_INIT;
    else if (go_uok)
      unb_q[pix] <= `PCDE_UNBLK_INIT; // RULE23
    else if (cmd_go && act == PCDE_ACT_UNB_MISS)
      unb_q[pix] <= 4'(unb_q[pix] - 4'h1);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      alt_use_q <= '0;
      for (int i = 0; i < NPIN; i++)
        alt_ref_q[i] <= 5'h0;
    end
    else if (go_alt)
    begin
      alt_use_q[pix] <= 1'b1; // RULE12
      alt_ref_q[pix] <= cmd.p1[4:0];
    end
    else if (go_end_alt)
      alt_use_q[pix] <= 1'b0; // RULE21
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < 32; i++)
        keyq_q[i] <= `PCDE_USE_NONE;
    else if (go_alt)
      keyq_q[cmd.p1[4:0]] <= `PCDE_USE_ALT; // RULE12
    else if (go_end_alt)
      keyq_q[alt_ref_q[pix]] <= `PCDE_USE_NONE; // RULE21
  end
  // epoch counts re-validations so software can spot a changed environment
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q     <= '0;
      last_cmd_q <= '0;
      reval_q    <= 1'b0;
    end
    else
    begin
      reval_q <= go_ok && (cmd.op == PCDE_OP_DISABLE || cmd.op == PCDE_OP_ENABLE); // RULE15
      if (cmd_go)
      begin
        stat_q.sw  <= sw_d; // RULE22 RULE24
        last_cmd_q <= cmd;
      end
      if (go_ok && (cmd.op == PCDE_OP_DISABLE || cmd.op == PCDE_OP_ENABLE))
        stat_q.epoch <= 16'(stat_q.epoch + 16'h1); // RULE15
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 4; i++)
        data_q[i] <= 32'h0;
      sel_q       <= 5'h1;
      file_refs_q <= '0;
    end
    else if (wr)
    begin
      case (paddr)
        `PCDE_A_DATA0:     data_q[0] <= pwdata;
        `PCDE_A_DATA1:     data_q[1] <= pwdata;
        `PCDE_A_DATA2:     data_q[2] <= pwdata;
        `PCDE_A_DATA3:     data_q[3] <= pwdata;
        `PCDE_A_SEL:       sel_q <= pwdata[4:0];
        `PCDE_A_FILE_REFS: file_refs_q <= pwdata[NPIN-1:0];
        default:           ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // access evaluation

  function automatic pcde_acc_e acc_of(input logic en, input logic b, input logic alt);
    if (!en)
      return alt ? PCDE_AC_ALT : PCDE_AC_ALWAYS; // RULE13 RULE20
    else if (b)
      return PCDE_AC_NEVER; // RULE4 RULE20
    else
      return PCDE_AC_VERIFY;
  endfunction
  pcde_acc_e     file_acc;
  logic [IW:0]   nref;
  logic          any_dis;
  always_comb
  begin
    file_acc = PCDE_AC_ALWAYS;
    nref     = '0;
    any_dis  = 1'b0;
    for (int i = 0; i < NPIN; i++)
    begin
      if (file_refs_q[i])
      begin
        nref     = (IW+1)'(nref + 1'b1);
        any_dis  = any_dis | ~ena_q[i];
        file_acc = acc_of(ena_q[i], retry_q[i] == 2'h0, alt_use_q[i]);
      end
    end
    // several references: one disabled opens the file
    if (nref > 1)
      file_acc = any_dis ? PCDE_AC_ALWAYS : PCDE_AC_VERIFY; // RULE14
  end
  logic [IW-1:0] vix;
  logic          sel_ok;
  logic [31:0]   pin_info;
  assign vix    = IW'(sel_q - 5'h1);
  assign sel_ok = (sel_q != 5'h0) && (int'(sel_q) <= NPIN);
  always_comb
  begin
    pin_info = 32'h0;
    if (sel_ok)
    begin
      pin_info[1:0]   = retry_q[vix];
      pin_info[2]     = ena_q[vix];
      pin_info[3]     = retry_q[vix] == 2'h0;
      pin_info[5:4]   = acc_of(ena_q[vix], retry_q[vix] == 2'h0, alt_use_q[vix]);
      pin_info[11:8]  = unb_q[vix];
      pin_info[12]    = alt_use_q[vix];
      pin_info[20:16] = alt_ref_q[vix];
    end
  end
  always_comb
  begin
    mapped = paddr[1:0] == 2'b00;
    rd_d   = 32'h0;
    case (paddr)
      `PCDE_A_CMD:       rd_d = last_cmd_q;
      `PCDE_A_DATA0:     rd_d = data_q[0];
      `PCDE_A_DATA1:     rd_d = data_q[1];
      `PCDE_A_DATA2:     rd_d = data_q[2];
      `PCDE_A_DATA3:     rd_d = data_q[3];
      `PCDE_A_STATUS:    rd_d = stat_q;
      `PCDE_A_SEL:       rd_d = {27'h0, sel_q};
      `PCDE_A_PIN_INFO:  rd_d = pin_info;
      `PCDE_A_FILE_REFS: rd_d = 32'(file_refs_q);
      `PCDE_A_FILE_ACC:  rd_d = 32'(file_acc);
      `PCDE_A_KEYQ:      rd_d = {24'h0, keyq_q[sel_q]};
      default:           mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_CHG_GUARD: assert property ( // RULE1
    cmd_go && cmd.op == PCDE_OP_CHANGE && ref_ok && (!ena_q[pix] || blk)
    |=> pin_val_q[$past(pix)] == $past(pin_val_q[pix]) && stat_q.sw != `PCDE_SW_OK)
    else $error("change ran on a disabled or blocked pin");
  AST_CHG_OK: assert property ( // RULE2
    go_ok && cmd.op == PCDE_OP_CHANGE
    |=> retry_q[$past(pix)] == `PCDE_RETRY_INIT && pin_val_q[$past(pix)] == $past(new_val))
    else $error("change did not reload retries or store new value");
  AST_MISS_DEC: assert property ( // RULE3
    go_miss |=> retry_q[$past(pix)] == 2'($past(retry_q[pix]) - 2'h1)
                && pin_val_q[$past(pix)] == $past(pin_val_q[pix]))
    else $error("mismatch did not decrement exactly once");
  AST_BLOCK_SW: assert property ( // RULE22
    go_miss && retry_q[pix] == 2'h1
    |=> stat_q.sw == 16'h63C0 && retry_q[$past(pix)] == 2'h0)
    else $error("third mismatch did not block with zero retries");
  AST_BLOCKED_REFUSE: assert property ( // RULE4
    cmd_go && cmd.op != PCDE_OP_UNBLOCK && p1_ok && ref_ok && lc_ok && blk
    |=> stat_q.sw == `PCDE_SW_BLOCKED && retry_q[$past(pix)] == 2'h0)
    else $error("blocked pin not reported as blocked");
  AST_DIS_OK: assert property ( // RULE7
    go_ok && cmd.op == PCDE_OP_DISABLE
    |=> !ena_q[$past(pix)] && retry_q[$past(pix)] == `PCDE_RETRY_INIT ##0 sec_env_reval ##1 !sec_env_reval)
    else $error("disable did not clear enable or pulse revalidation");
  AST_DIS_REFUSE: assert property ( // RULE9
    cmd_go && cmd.op == PCDE_OP_DISABLE && p1_ok && ref_ok && lc_ok && (!ena_q[pix] || blk)
    |=> stat_q.sw inside {`PCDE_SW_COND, `PCDE_SW_BLOCKED} && ena_q[$past(pix)] == $past(ena_q[pix]))
    else $error("disable executed on disabled or blocked pin");
  AST_ALT_SET: assert property ( // RULE12
    go_alt |=> keyq_q[$past(cmd.p1[4:0])] == `PCDE_USE_ALT && alt_use_q[$past(pix)])
    else $error("substitute qualifier not set");
  AST_ENA_END_ALT: assert property ( // RULE21
    go_ok && cmd.op == PCDE_OP_ENABLE && alt_use_q[pix]
    |=> keyq_q[$past(alt_ref_q[pix])] == `PCDE_USE_NONE && !alt_use_q[$past(pix)] && ena_q[$past(pix)])
    else $error("enable did not end substitution");
  AST_ENA_MISS: assert property ( // RULE18
    go_miss && cmd.op == PCDE_OP_ENABLE |=> !ena_q[$past(pix)] && stat_q.sw[15:4] == `PCDE_SW_RETRY)
    else $error("enable mismatch changed enable state");
  // counted independently of the evaluation loop
  AST_FILE_MULTI: assert property ( // RULE14
    $countones(file_refs_q) > 1 && |(file_refs_q & ~ena_q) |-> file_acc == PCDE_AC_ALWAYS)
    else $error("multi-reference file not opened by a disabled key");
  AST_UNB_OK: assert property ( // RULE23
    go_uok |=> unb_q[$past(pix)] == `PCDE_UNBLK_INIT && retry_q[$past(pix)] == `PCDE_RETRY_INIT
               && ena_q[$past(pix)])
    else $error("unlock did not restore counters");
  AST_REFUSE_STILL: assert property ( // RULE24
    cmd_go && act == PCDE_ACT_NONE && cmd.op != PCDE_OP_UNBLOCK && ref_ok
    |=> $stable(ena_q) && retry_q[$past(pix)] == $past(retry_q[pix]) && stat_q.sw != `PCDE_SW_OK)
    else $error("refused request changed state");
  AST_APB_WAIT: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");
  COV_CHG_OK:  cover property (go_ok && cmd.op == PCDE_OP_CHANGE);
  COV_BLOCK:   cover property (go_miss && retry_q[pix] == 2'h1);
  COV_DIS_ALT: cover property (go_alt);
  COV_ENA_OK:  cover property (go_ok && cmd.op == PCDE_OP_ENABLE);

endmodule

// ---- test/pcde_term.sv ----
`timescale 1ns/1ps

module pcde_term
(
  // clock
  input  wire logic        pclk,
  // request side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  // answer side
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // entered just after a rising edge; no cycle count assumed, the bench timeout cuts a hang
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle edge so no signal is written twice in one step
    @(posedge pclk);
  endtask
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "pcde_defines.svh"

module tb_top
  import pcde_pkg::*;
;
  // start and unlock values are arbitrary
  localparam logic [63:0] PIN0 = 64'h0000_0000_3433_3231;
  localparam logic [63:0] UNB  = 64'h1122_3344_5566_7788;
  localparam logic [63:0] PNEW = 64'hA5A5_0F0F_1234_5678;
  localparam logic [63:0] BAD  = 64'hDEAD_BEEF_0BAD_F00D;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sec_env_reval;
  logic [31:0] rdv;
  logic        err;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          reval_cnt = 0;

  pcde_pin_cmd #(.NPIN(4), .PIN_INIT(PIN0), .UNBLOCK_CODE(UNB)) uut
  (
    .pclk          (pclk),
    .presetn       (presetn),
    .psel          (psel),
    .penable       (penable),
    .pwrite        (pwrite),
    .paddr         (paddr),
    .pwdata        (pwdata),
    .prdata        (prdata),
    .pready        (pready),
    .pslverr       (pslverr),
    .sec_env_reval (sec_env_reval)
  );

  pcde_term term
  (
    .pclk    (pclk),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // whole run needs under a thousand cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (sec_env_reval === 1'b1)
      reval_cnt++;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    term.xfer(1'b1, a, d, rdv, err);
  endtask

  task automatic rd(input logic [11:0] a);
    term.xfer(1'b0, a, 32'h0000_0000, rdv, err);
  endtask

  task automatic look(input logic [11:0] sa, input logic [31:0] sv, input logic [11:0] ra,
                      input logic [31:0] exp);
    wr(sa, sv);
    rd(ra);
    chk("view register", exp, rdv);
  endtask

  function automatic logic [31:0] pi(input logic [1:0] rt, input logic en, input logic blk,
                                     input logic [1:0] acc, input logic sub, input logic [4:0] sr);
    return {11'h000, sr, 3'h0, sub, 4'hA, 2'h0, acc, blk, en, rt};
  endfunction

  task automatic pin(input logic [4:0] pr, input logic [31:0] exp);
    look(`PCDE_A_SEL, {27'h0000000, pr}, `PCDE_A_PIN_INFO, exp);
  endtask

  // frame: value in DATA0/1, second value in DATA2/3, then command word
  task automatic cmd(input pcde_op_e op, input logic [7:0] p1, input logic [7:0] p2,
                     input logic [7:0] lc, input logic [63:0] v, input logic [63:0] nv,
                     input logic [15:0] sw);
    wr(`PCDE_A_DATA0, v[31:0]);
    wr(`PCDE_A_DATA1, v[63:32]);
    wr(`PCDE_A_DATA2, nv[31:0]);
    wr(`PCDE_A_DATA3, nv[63:32]);
    wr(`PCDE_A_CMD, {lc, p2, p1, 5'h00, op});
    rd(`PCDE_A_STATUS);
    chk("status word", {16'h0000, sw}, {16'h0000, rdv[15:0]});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 1; i <= 4; i++)
      pin(5'(i), pi(2'h3, 1'b1, 1'b0, 2'h0, 1'b0, 5'h00));
    cmd(PCDE_OP_CHANGE, 8'h00, 8'h01, 8'h10, BAD, PNEW, 16'h63C2);
    pin(5'h01, pi(2'h2, 1'b1, 1'b0, 2'h0, 1'b0, 5'h00));
    cmd(PCDE_OP_CHANGE, 8'h00, 8'h01, 8'h10, PIN0, PNEW, 16'h9000);
    pin(5'h01, pi(2'h3, 1'b1, 1'b0, 2'h0, 1'b0, 5'h00));
    cmd(PCDE_OP_CHANGE, 8'h00, 8'h01, 8'h10, PIN0, PIN0, 16'h63C2);
    cmd(PCDE_OP_CHANGE, 8'h00, 8'h01, 8'h08, PNEW, PIN0, 16'h6700);
    cmd(PCDE_OP_CHANGE, 8'h01, 8'h01, 8'h10, PNEW, PIN0, 16'h6A86);
    // substitute reference 2 chosen while disabling
    cmd(PCDE_OP_DISABLE, 8'h82, 8'h01, 8'h08, PNEW, BAD, 16'h9000);
    pin(5'h01, pi(2'h3, 1'b0, 1'b0, 2'h2, 1'b1, 5'h02));
    look(`PCDE_A_SEL, 32'h0000_0002, `PCDE_A_KEYQ, 32'h0000_0008);
    look(`PCDE_A_FILE_REFS, 32'h0000_0001, `PCDE_A_FILE_ACC, 32'h0000_0002);
    look(`PCDE_A_FILE_REFS, 32'h0000_0003, `PCDE_A_FILE_ACC, 32'h0000_0001);
    cmd(PCDE_OP_DISABLE, 8'h00, 8'h01, 8'h08, PNEW, BAD, 16'h6985);
    cmd(PCDE_OP_CHANGE, 8'h00, 8'h01, 8'h10, PNEW, PIN0, 16'h6985);
    pin(5'h01, pi(2'h3, 1'b0, 1'b0, 2'h2, 1'b1, 5'h02));
    cmd(PCDE_OP_ENABLE, 8'h00, 8'h01, 8'h08, BAD, BAD, 16'h63C2);
    pin(5'h01, pi(2'h2, 1'b0, 1'b0, 2'h2, 1'b1, 5'h02));
    cmd(PCDE_OP_ENABLE, 8'h00, 8'h01, 8'h08, PNEW, BAD, 16'h9000);
    // substitute number stays readable after the substitution ends
    pin(5'h01, pi(2'h3, 1'b1, 1'b0, 2'h0, 1'b0, 5'h02));
    look(`PCDE_A_SEL, 32'h0000_0002, `PCDE_A_KEYQ, 32'h0000_0000);
    cmd(PCDE_OP_ENABLE, 8'h00, 8'h01, 8'h08, PNEW, BAD, 16'h6985);
    cmd(PCDE_OP_DISABLE, 8'h01, 8'h01, 8'h08, PNEW, BAD, 16'h6A86);
    cmd(PCDE_OP_DISABLE, 8'hA2, 8'h01, 8'h08, PNEW, BAD, 16'h6A86);
    cmd(PCDE_OP_DISABLE, 8'h00, 8'h01, 8'h10, PNEW, BAD, 16'h6700);
    // three wrong values in a row block the PIN
    for (int k = 0; k < 3; k++)
      cmd(PCDE_OP_DISABLE, 8'h00, 8'h03, 8'h08, BAD, BAD, 16'h63C2 - 16'(k));
    pin(5'h03, pi(2'h0, 1'b1, 1'b1, 2'h3, 1'b0, 5'h00));
    cmd(PCDE_OP_DISABLE, 8'h00, 8'h03, 8'h08, PIN0, BAD, 16'h6983);
    cmd(PCDE_OP_CHANGE, 8'h00, 8'h03, 8'h10, PIN0, PNEW, 16'h6983);
    look(`PCDE_A_FILE_REFS, 32'h0000_0004, `PCDE_A_FILE_ACC, 32'h0000_0003);
    cmd(PCDE_OP_UNBLOCK, 8'h00, 8'h03, 8'h10, BAD, PNEW, 16'h63C9);
    cmd(PCDE_OP_UNBLOCK, 8'h00, 8'h03, 8'h10, UNB, PNEW, 16'h9000);
    pin(5'h03, pi(2'h3, 1'b1, 1'b0, 2'h0, 1'b0, 5'h00));
    cmd(PCDE_OP_CHANGE, 8'h00, 8'h03, 8'h10, PNEW, PIN0, 16'h9000);
    cmd(PCDE_OP_DISABLE, 8'h00, 8'h04, 8'h08, PIN0, BAD, 16'h9000);
    for (int k = 0; k < 3; k++)
      cmd(PCDE_OP_ENABLE, 8'h00, 8'h04, 8'h08, BAD, BAD, 16'h63C2 - 16'(k));
    pin(5'h04, pi(2'h0, 1'b0, 1'b1, 2'h1, 1'b0, 5'h00));
    look(`PCDE_A_FILE_REFS, 32'h0000_0008, `PCDE_A_FILE_ACC, 32'h0000_0001);
    cmd(PCDE_OP_ENABLE, 8'h00, 8'h04, 8'h08, PIN0, BAD, 16'h6983);
    cmd(pcde_op_e'(3'h5), 8'h00, 8'h01, 8'h08, PIN0, BAD, 16'h6D00);
    // bus refusals and a read-only write
    wr(12'h100, 32'hFFFF_FFFF);
    chk("slave error", 32'h0000_0001, {31'h00000000, err});
    rd(12'h006);
    chk("slave error", 32'h0000_0001, {31'h00000000, err});
    chk("refused read", 32'h0000_0000, rdv);
    wr(`PCDE_A_STATUS, 32'hFFFF_FFFF);
    rd(`PCDE_A_STATUS);
    chk("epoch", 32'h0000_0003, {16'h0000, rdv[31:16]});
    chk("revalidations", 32'h0000_0003, 32'(reval_cnt));
    conclude();
  end
endmodule
